//--- design/ofw_regs.v
// frequency offset word and software output enable, reached over the two-wire bus
// assumes bus pins are open drain and sampled here; sys_clk well above the bus rate
//
// Functional notes
// - low 16 bits of the signed offset word live at offset 0x00, read/write.
// - upper 10 bits live in bits 9:0 at offset 0x01, above the low word.
// - all 26 word bits are zero after reset, giving nominal frequency.
// - the 26-bit word is two's complement, positive and negative offsets.
// - host writes low word first; change starts only on upper word write.
// - bit 10 at offset 0x01 is software output enable, default off.
// - software enable bit acts only under software control; else writes ignored.
// - bits 15:11 at offset 0x01 read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
`include "ofw_consts.vh"

module ofw_regs #(
   parameter [6:0] DEV_ADDR = `OFW_DEV_ADDR  // bus address, value arbitrary
) (
   // clock, reset, enable
   input  wire                    sys_clk,
   input  wire                    rst,
   input  wire                    ce,
   // two-wire serial bus
   input  wire                    scl_i,
   input  wire                    sda_i,
   output reg                     sda_o,
   output reg                     sda_oe_n,
   // output enable control
   input  wire                    oe_pin,
   input  wire                    oe_sw_ctrl,
   output reg                     out_en,
   // applied frequency word
   output reg  [`OFW_WORD_W-1:0]  freq_word,
   output reg                     freq_load
);

   // ********************************************
   // states
   // ********************************************
   localparam [8:0] ST_IDLE = 9'h001;
   localparam [8:0] ST_ADDR = 9'h002;
   localparam [8:0] ST_AACK = 9'h004;
   localparam [8:0] ST_PTR  = 9'h008;
   localparam [8:0] ST_PACK = 9'h010;
   localparam [8:0] ST_WR   = 9'h020;
   localparam [8:0] ST_WACK = 9'h040;
   localparam [8:0] ST_RD   = 9'h080;
   localparam [8:0] ST_RACK = 9'h100;

   // ********************************************
   // pin sampling
   // ********************************************
   wire [2:0] p_lvl;
   wire [2:0] p_rise;
   wire [2:0] p_fall;

   ofw_pin_sync #(.W(3)) u_sync (
      .sys_clk (sys_clk),
      .rst     (rst),
      .ce      (ce),
      .pin_i   ({oe_pin, sda_i, scl_i}),
      .lvl     (p_lvl),
      .rise    (p_rise),
      .fall    (p_fall)
   );

   wire scl_rise = p_rise[0];
   wire scl_fall = p_fall[0];
   wire sda_lvl  = p_lvl[1];
   wire bus_start = p_fall[1] & p_lvl[0];
   wire bus_stop  = p_rise[1] & p_lvl[0];
   wire oe_pin_s  = p_lvl[2];

   // ********************************************
   // registers
   // ********************************************
   reg [8:0]             state_q;
   reg [2:0]             cnt_q;
   reg [6:0]             shift_q;
   reg [7:0]             ptr_q;
   reg                   byte_sel_q;
   reg                   ack_on_q;
   reg [7:0]             wr_hi_q;
   reg [7:0]             tx_q;
   reg [7:0]             rd_lo_q;
   reg [`OFW_LOW_W-1:0]  low_stage_q;
   reg [`OFW_HIGH_W-1:0] high_q;
   reg                   oe_bit_q;

   wire [7:0] rx_byte = {shift_q, sda_lvl};

   // read view of a register; unmapped offsets read zero
   function [15:0] rd_reg;
      input [7:0] ofs;
      begin
         if (ofs == `OFW_OFS_LOW)
            rd_reg = low_stage_q;
         else if (ofs == `OFW_OFS_HIGH)
            rd_reg = {5'h00, oe_bit_q, high_q};
         else
            rd_reg = 16'h0000;
      end
   endfunction

   wire [15:0] rd_now  = rd_reg(ptr_q);
   wire [15:0] rd_next = rd_reg(ptr_q + 8'h01);

   // ********************************************
   // bus engine and register writes
   // ********************************************
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_q     <= ST_IDLE;
         cnt_q       <= 3'h0;
         shift_q     <= 7'h00;
         ptr_q       <= 8'h00;
         byte_sel_q  <= 1'b0;
         ack_on_q    <= 1'b0;
         wr_hi_q     <= 8'h00;
         tx_q        <= 8'h00;
         rd_lo_q     <= 8'h00;
         low_stage_q <= `OFW_LOW_RST;
         high_q      <= `OFW_HIGH_RST;
         oe_bit_q    <= `OFW_OE_RST;
         freq_word   <= `OFW_WORD_RST;
         freq_load   <= 1'b0;
         sda_o       <= 1'b0;
         sda_oe_n    <= 1'b1;
         out_en      <= 1'b0;
      end else if (ce) begin
         freq_load <= 1'b0;
         // hardware pin governs unless configured for software control
         out_en    <= oe_sw_ctrl ? oe_bit_q : oe_pin_s;
         if (bus_start) begin
            state_q  <= ST_ADDR;
            cnt_q    <= 3'h0;
            ack_on_q <= 1'b0;
            sda_oe_n <= 1'b1;
         end else if (bus_stop) begin
            state_q  <= ST_IDLE;
            sda_oe_n <= 1'b1;
         end else begin
            case (state_q)
               ST_ADDR, ST_PTR, ST_WR: begin
                  if (scl_rise) begin
                     shift_q <= rx_byte[6:0];
                     cnt_q   <= cnt_q + 3'h1;
                     if (cnt_q == 3'h7) begin
                        if (state_q == ST_ADDR) begin
                           // not our address: stay quiet until the next start
                           if (rx_byte[7:1] == DEV_ADDR) begin
                              state_q    <= ST_AACK;
                              byte_sel_q <= rx_byte[0];
                           end else begin
                              state_q <= ST_IDLE;
                           end
                        end else if (state_q == ST_PTR) begin
                           ptr_q      <= rx_byte;
                           byte_sel_q <= 1'b0;
                           state_q    <= ST_PACK;
                        end else begin
                           state_q    <= ST_WACK;
                           byte_sel_q <= ~byte_sel_q;
                           if (!byte_sel_q) begin
                              wr_hi_q <= rx_byte;
                           end else begin
                              ptr_q <= ptr_q + 8'h01;
                              if (ptr_q == `OFW_OFS_LOW) begin
                                 // staged only; the oscillator keeps its old word
                                 low_stage_q <= {wr_hi_q, rx_byte};
                              end else if (ptr_q == `OFW_OFS_HIGH) begin
                                 high_q    <= {wr_hi_q[1:0], rx_byte};
                                 // bits 15:11 are dropped here
                                 if (oe_sw_ctrl)
                                    oe_bit_q <= wr_hi_q[`OFW_OE_POS-8];
                                 // whole signed word applied in one step
                                 freq_word <= {wr_hi_q[1:0], rx_byte, low_stage_q};
                                 freq_load <= 1'b1;
                              end
                           end
                        end
                     end
                  end
               end
               ST_AACK, ST_PACK, ST_WACK: begin
                  if (scl_fall) begin
                     if (!ack_on_q) begin
                        sda_oe_n <= 1'b0;
                        ack_on_q <= 1'b1;
                     end else begin
                        ack_on_q <= 1'b0;
                        cnt_q    <= 3'h0;
                        if (state_q == ST_AACK && byte_sel_q) begin
                           // read: first bit goes out on this same fall
                           state_q    <= ST_RD;
                           byte_sel_q <= 1'b0;
                           rd_lo_q    <= rd_now[7:0];
                           sda_oe_n   <= rd_now[15];
                           tx_q       <= {rd_now[14:8], 1'b1};
                        end else begin
                           state_q  <= (state_q == ST_AACK) ? ST_PTR : ST_WR;
                           sda_oe_n <= 1'b1;
                        end
                     end
                  end
               end
               ST_RD: begin
                  if (scl_rise) begin
                     cnt_q <= cnt_q + 3'h1;
                     if (cnt_q == 3'h7)
                        state_q <= ST_RACK;
                  end else if (scl_fall) begin
                     sda_oe_n <= tx_q[7];
                     tx_q     <= {tx_q[6:0], 1'b1};
                  end
               end
               ST_RACK: begin
                  if (scl_fall && !ack_on_q) begin
                     sda_oe_n <= 1'b1;
                  end else if (scl_rise) begin
                     // a not-acknowledge ends the read
                     if (sda_lvl)
                        state_q <= ST_IDLE;
                     else
                        ack_on_q <= 1'b1;
                  end else if (scl_fall) begin
                     ack_on_q <= 1'b0;
                     cnt_q    <= 3'h0;
                     state_q  <= ST_RD;
                     if (!byte_sel_q) begin
                        byte_sel_q <= 1'b1;
                        sda_oe_n   <= rd_lo_q[7];
                        tx_q       <= {rd_lo_q[6:0], 1'b1};
                     end else begin
                        byte_sel_q <= 1'b0;
                        ptr_q      <= ptr_q + 8'h01;
                        rd_lo_q    <= rd_next[7:0];
                        sda_oe_n   <= rd_next[15];
                        tx_q       <= {rd_next[14:8], 1'b1};
                     end
                  end
               end
               ST_IDLE: begin
                  sda_oe_n <= 1'b1;
               end
               default: begin
                  state_q  <= ST_IDLE;
                  sda_oe_n <= 1'b1;
               end
            endcase
         end
      end
   end

endmodule // ofw_regs

`default_nettype wire

//--- common/ofw_consts.vh
// register offsets, field positions and reset values of the frequency word slice
// assumes inclusion by bare name from the design files
`ifndef OFW_CONSTS_VH
`define OFW_CONSTS_VH

`define OFW_OFS_LOW      8'h00
`define OFW_OFS_HIGH     8'h01
`define OFW_LOW_W        16
`define OFW_HIGH_W       10
`define OFW_WORD_W       26
`define OFW_HIGH_MSB     9
`define OFW_OE_POS       10
`define OFW_LOW_RST      16'h0000
`define OFW_HIGH_RST     10'h000
`define OFW_OE_RST       1'b0
`define OFW_WORD_RST     26'h000_0000
`define OFW_DEV_ADDR     7'h3a

`endif

//--- design/ofw_pin_sync.v
// two-flop synchroniser with edge detection for the serial bus pins
// assumes pins are asynchronous to sys_clk and ce freezes all state
`timescale 1ns/1ps
`default_nettype none

module ofw_pin_sync #(
   parameter W = 2
) (
   // clock and reset
   input  wire         sys_clk,
   input  wire         rst,
   input  wire         ce,
   // pins in
   input  wire [W-1:0] pin_i,
   // synchronised view
   output wire [W-1:0] lvl,
   output wire [W-1:0] rise,
   output wire [W-1:0] fall
);

   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;
   reg [W-1:0] prev_q;

   // only sync_q looks at meta_q; edges come from the settled stages
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         meta_q <= {W{1'b1}};
         sync_q <= {W{1'b1}};
         prev_q <= {W{1'b1}};
      end else if (ce) begin
         meta_q <= pin_i;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   assign lvl  = sync_q;
   assign rise = sync_q & ~prev_q;
   assign fall = ~sync_q & prev_q;

endmodule // ofw_pin_sync

`default_nettype wire

//--- sim/ofw_regs_monitor.sv
// port assertions for the frequency word slice
// assumes a bind onto ofw_regs and one clock domain
`timescale 1ns/1ps
`default_nettype none
`include "ofw_consts.vh"
module ofw_regs_mon (
   // clock, reset, enable
   input wire logic                   sys_clk,
   input wire logic                   rst,
   input wire logic                   ce,
   // bus, enables and word
   input wire logic                   scl_i,
   input wire logic                   sda_i,
   input wire logic                   sda_o,
   input wire logic                   sda_oe_n,
   input wire logic                   oe_pin,
   input wire logic                   oe_sw_ctrl,
   input wire logic                   out_en,
   input wire logic [`OFW_WORD_W-1:0] freq_word,
   input wire logic                   freq_load
);
   // *****
   // checks
   // *****
   logic [7:0] gap_q;
   // saturates, so the first load after reset is never judged too early
   always_ff @(posedge sys_clk or posedge rst)
      if (rst) gap_q <= 8'hff;
      else gap_q <= freq_load ? 8'h00 : gap_q + {7'h00, gap_q != 8'hff};
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   sequence pin_quiet; ce && !oe_sw_ctrl && $stable(oe_pin); endsequence
   sequence sw_quiet; ce && oe_sw_ctrl && !freq_load; endsequence
   word_reset_a: assert property ($fell(rst) |-> freq_word == '0)
      else $error("word not zero after reset");
   oe_reset_a: assert property ($fell(rst) |-> !out_en && !freq_load)
      else $error("enable or load set after reset");
   word_change_a: assert property ($changed(freq_word) |-> freq_load)
      else $error("word moved without load");
   load_single_a: assert property (freq_load |=> !freq_load)
      else $error("load longer than one cycle");
   load_released_a: assert property (freq_load |-> sda_oe_n)
      else $error("load while acknowledging");
   load_spacing_a: assert property (freq_load |-> gap_q > 8'h64)
      else $error("loads closer than one word");
   pin_follow_a: assert property (pin_quiet [*6] |-> out_en == oe_pin)
      else $error("enable not following pin");
   sw_hold_a: assert property (sw_quiet [*3] |-> $stable(out_en))
      else $error("enable moved without upper write");
endmodule // ofw_regs_mon
bind ofw_regs ofw_regs_mon u_ofw_regs_mon (.sys_clk(sys_clk), .rst(rst), .ce(ce),
   .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .oe_pin(oe_pin),
   .oe_sw_ctrl(oe_sw_ctrl), .out_en(out_en), .freq_word(freq_word), .freq_load(freq_load));
`default_nettype wire

//--- sim/ofw_host.sv
// two-wire bus host that writes and reads the slice
// assumes the bench resolves the open-drain data wire with a pull-up
`timescale 1ns/1ps
`default_nettype none
module ofw_host (
   // clock
   input  wire logic sys_clk,
   // bus
   output logic      scl,
   output logic      sda_low,
   input  wire logic sda
);
   // *****
   // bus cycles
   // *****
   time last_t = 0;
   initial set(1'b1, 1'b0);
   // one quarter of the 160 ns bus period
   task automatic set(input logic c, input logic l);
      scl = c;
      sda_low = l;
      repeat (2) @(posedge sys_clk);
      #1;
   endtask
   task automatic byte_io(input logic [8:0] d, output logic [8:0] r);
      for (int i = 8; i >= 0; i--) begin
         set(1'b0, !d[i]);
         set(1'b1, !d[i]);
         r[i] = sda;
         set(1'b1, !d[i]);
         set(1'b0, !d[i]);
      end
   endtask
   task automatic xfer(input logic [6:0] a, input logic [7:0] p, input logic [31:0] d,
                       input int n, input logic rd, output logic ok, output logic [31:0] r);
      logic [8:0] x;
      // spacing kept for every transfer: simpler than tracking upper writes only
      while ($time - last_t < 26316) @(posedge sys_clk);
      #1;
      for (int j = 0; j <= int'(rd); j++) begin
         // keep scl low until the device has let go of its ack, or the release reads as a stop
         if (j == 1) set(1'b0, 1'b0);
         set(1'b1, 1'b0);
         set(1'b1, 1'b1);
         set(1'b0, 1'b1);
         byte_io({a, j[0], 1'b1}, x);
         ok = !x[0];
         if (j == 0) byte_io({p, 1'b1}, x);
      end
      for (int i = 0; i < n; i++) begin
         byte_io({(rd ? 8'hff : d[31-8*i -: 8]), !(rd && i < n - 1)}, x);
         r[31-8*i -: 8] = x[8:1];
      end
      set(1'b0, 1'b1);
      set(1'b1, 1'b1);
      set(1'b1, 1'b0);
      last_t = $time;
   endtask
endmodule // ofw_host
`default_nettype wire

//--- sim/ofw_regs_tb.sv
// self-checking bench for the frequency word slice
// assumes ofw_host as bus master and a pull-up on the data wire
`timescale 1ns/1ps
`default_nettype none
`include "ofw_consts.vh"
module ofw_regs_tb;
   // *****
   // bench
   // *****
   logic                   sys_clk;
   logic                   rst;
   logic                   oe_pin;
   logic                   oe_sw_ctrl;
   logic                   scl;
   logic                   sda_low;
   logic                   ce;
   logic                   sda_o;
   logic                   sda_oe_n;
   logic                   out_en;
   logic                   freq_load;
   logic [`OFW_WORD_W-1:0] freq_word;
   // open drain: the device's level reaches the wire only while it is enabled
   wire                    sda = !sda_low && (sda_oe_n || sda_o);
   logic [31:0]            seed = 32'h0000_0035;
   int                     num_errors = 0;
   int                     check_count = 0;
   int                     loads = 0;
   int                     cyc = 0;
   int                     m_lo = 0;
   int                     m_oe = 0;
   int                     m_word = 0;
   int                     m_loads = 0;
   ofw_regs u_ofw_regs (.sys_clk(sys_clk), .rst(rst), .ce(ce), .scl_i(scl), .sda_i(sda),
      .sda_o(sda_o), .sda_oe_n(sda_oe_n), .oe_pin(oe_pin), .oe_sw_ctrl(oe_sw_ctrl),
      .out_en(out_en), .freq_word(freq_word), .freq_load(freq_load));
   ofw_host u_ofw_host (.sys_clk(sys_clk), .scl(scl), .sda_low(sda_low), .sda(sda));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string s);
      check_count++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH %0t %s got %h exp %h", $time, s, g, e);
      end
   endtask
   task automatic final_report;
      if (num_errors == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic settle;
      logic        ok;
      logic [31:0] r;
      repeat (6) @(posedge sys_clk);
      #1;
      chk({6'h00, freq_word}, m_word[25:0], "word");
      chk(loads, m_loads, "loads");
      chk({31'h0, out_en}, oe_sw_ctrl ? m_oe[0] : oe_pin, "enable");
      u_ofw_host.xfer(`OFW_DEV_ADDR, 8'h00, 0, 4, 1'b1, ok, r);
      chk(r, {m_lo[15:0], 5'h00, m_oe[0], m_word[25:16]}, "read");
   endtask
   task automatic put(input logic [7:0] p, input logic [31:0] d, input int n);
      logic        ok;
      logic [31:0] r;
      logic [15:0] v;
      u_ofw_host.xfer(`OFW_DEV_ADDR, p, d, n, 1'b0, ok, r);
      chk({31'h0, ok}, 1, "no ack");
      for (int k = 0; k < n / 2; k++) begin
         v = d[31-16*k -: 16];
         m_lo = (p + k == 0) ? v : m_lo;
         if (p + k == 1) begin
            m_oe = oe_sw_ctrl ? v[10] : m_oe;
            m_word = {v[9:0], m_lo[15:0]};
            m_loads++;
         end
      end
      settle;
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   // counted away from the launching edge so the pulse is read where it is settled
   always @(negedge sys_clk) begin
      cyc++;
      loads += int'(freq_load === 1'b1);
      if (cyc == 80000) begin
         chk(0, 1, "timeout");
         final_report;
      end
   end
   initial begin
      logic [31:0] d;
      logic        ok;
      int          w;
      rst = 1'b1;
      ce = 1'b1;
      oe_pin = 1'b0;
      oe_sw_ctrl = 1'b0;
      repeat (20) @(posedge sys_clk);
      #1;
      rst = 1'b0;
      repeat (3) @(posedge sys_clk);
      settle;
      for (int i = 0; i < 6; i++) begin
         w = (i < 2) ? (20 * 32'h01ff_ffff + 50) / 100 : rnd();
         w = (i == 1) ? -w : w;
         d = rnd();
         oe_pin = d[0];
         oe_sw_ctrl = d[1];
         put(8'h00, {w[15:0], 16'h0000}, 2);
         put(8'h01, {d[15:10], w[25:16], 16'h0000}, 2);
      end
      put(8'h00, rnd(), 4);
      put(8'h01, rnd(), 1);
      u_ofw_host.xfer(`OFW_DEV_ADDR ^ 7'h01, 8'h00, rnd(), 2, 1'b0, ok, d);
      chk({31'h0, ok}, 0, "foreign ack");
      settle;
      u_ofw_host.xfer(`OFW_DEV_ADDR, 8'h01, 0, 4, 1'b1, ok, d);
      chk(d[15:0], 0, "unmapped");
      chk(d[31:16], {5'h00, m_oe[0], m_word[25:16]}, "upper");
      // clock enable low must freeze the pin path and the enable output
      oe_sw_ctrl = 1'b0;
      repeat (8) @(posedge sys_clk);
      #1;
      ce = 1'b0;
      oe_pin = ~oe_pin;
      repeat (8) @(posedge sys_clk);
      #1;
      chk({31'h0, out_en}, {31'h0, ~oe_pin}, "frozen");
      ce = 1'b1;
      settle;
      final_report;
   end
endmodule // ofw_regs_tb
`default_nettype wire
